/* File: core/uidr_defines.svh */
`ifndef UIDR_DEFINES_SVH
`define UIDR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UIDR_OFS_LCR      12'h02c
`define UIDR_OFS_CR       12'h030
`define UIDR_OFS_IFLS     12'h034
`define UIDR_OFS_IMSC     12'h038
`define UIDR_OFS_RIS      12'h03c
`define UIDR_OFS_MIS      12'h040
`define UIDR_OFS_ICR      12'h044
`define UIDR_OFS_DMACR    12'h048

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UIDR_LCR_FIFO_EN  4
`define UIDR_CR_PORT_EN   0
`define UIDR_DMA_RX_EN    0
`define UIDR_DMA_TX_EN    1
`define UIDR_DMA_ON_ERR   2
`define UIDR_IFLS_TX_LSB  0
`define UIDR_IFLS_RX_LSB  3
`define UIDR_IRQ_RING     0
`define UIDR_IRQ_CTS      1
`define UIDR_IRQ_DCD      2
`define UIDR_IRQ_DSR      3
`define UIDR_IRQ_RX       4
`define UIDR_IRQ_TX       5
`define UIDR_IRQ_RT       6
`define UIDR_IRQ_FE       7
`define UIDR_IRQ_PE       8
`define UIDR_IRQ_BE       9
`define UIDR_IRQ_OE       10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UIDR_RST_LCR      8'h00
`define UIDR_RST_CR       16'h0300
`define UIDR_RST_IFLS     6'h12
`define UIDR_RST_IMSC     11'h000
`define UIDR_RST_DMACR    3'h0

// ----------------------------------------------------------------
// Sizes and timing counts
// ----------------------------------------------------------------
`define UIDR_FIFO_DEPTH   6'd32
`define UIDR_TO_BITS      32
`define UIDR_OVERSAMPLE   16
`define UIDR_TO_TICKS     (`UIDR_TO_BITS * `UIDR_OVERSAMPLE)

`endif

/* File: core/uidr_pkg.sv */
package uidr_pkg;

  // Watermark select codes, eighths of the FIFO
  typedef enum logic [2:0] {
    WM_1_8 = 3'h0,
    WM_1_4 = 3'h1,
    WM_1_2 = 3'h2,
    WM_3_4 = 3'h3,
    WM_7_8 = 3'h4
  } uidr_wm_t;

  typedef logic [10:0] uidr_irq_vec_t;
  typedef logic [5:0]  uidr_level_t;

endpackage

/* File: core/uidr_rx_timeout.sv */
`timescale 1ns/10ps
`include "uidr_defines.svh"

module uidr_rx_timeout (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Receive side events
  input  wire logic tick_i,
  input  wire logic restart_i,
  input  wire logic nonempty_i,
  // Expiry pulse
  output logic      timeout_o
);

  localparam logic [9:0] LIMIT = 10'(`UIDR_TO_TICKS);

  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic       to_reg;
  wire        expire_w = tick_i && (cnt_reg == LIMIT - 10'h001) && nonempty_i && !restart_i;

  // Counts oversample ticks, restarted by each new character
  assign cnt_next = (!nonempty_i || restart_i) ? 10'h000 :
                    (tick_i && cnt_reg != LIMIT) ? cnt_reg + 10'h001 : cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 10'h000;
      to_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      to_reg  <= expire_w;
    end
  end

  assign timeout_o = to_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_timeout_fires: assert property (expire_w |=> timeout_o)
    else $error("timeout did not fire after full period");
  a_timeout_needs_data: assert property (timeout_o |-> $past(nonempty_i) && $past(cnt_reg) == LIMIT - 10'h001)
    else $error("timeout fired early or while empty");

endmodule // uidr_rx_timeout

/* File: core/uidr_core.sv */
`timescale 1ns/10ps
`include "uidr_defines.svh"

// How it works
// - Single and burst requests are independent; both assert at or above receive watermark.
// - Receive fill below watermark but non-empty raises only single receive request.
// - A request stays asserted until its matching clear input is raised.
// - After clear is released a request may reassert when its condition holds.
// - Port disable or cleared direction DMA enable drops that direction's requests.
// - With FIFOs off only single requests can assert; bursts stay low.
// - Transmit burst triggers on 28, 24, 16, 8, 4 free locations per watermark.
// - Receive burst triggers on 4, 8, 16, 24, 28 filled locations per watermark.
// - Block-on-error masks both receive requests while error interrupt is set.
// - Requests and clears are all synchronous to the bus clock.
// - Eleven maskable interrupt sources; only the combined output leaves the block.
// - A mask bit of one enables its source, zero masks it.
// - Modem interrupts set on any modem input change, cleared by writing one.
// - FIFO mode receive interrupt sets at trigger level, clears below or by clear.
// - Character mode receive interrupt sets when filled, clears on read or clear.
// - FIFO mode transmit interrupt sets at or below trigger, clears above or by clear.
// - Character mode transmit interrupt sets when empty, clears on write or clear.
// - Transmit interrupt sets on a transition into its condition, never by level.
// - Receive timeout sets when non-empty with no data for 32 bit periods.
// - Framing, parity, break, overrun set error bits, cleared by clear bits 7 to 10.
// - Combined interrupt is the OR of all masked sources.
// - Single receive request asserts while receive FIFO holds a character.
// - Single transmit request asserts while transmit FIFO has a free location.
// - Receive and transmit watermarks are selected separately in the level register.
module uidr_core (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // FIFO status from the datapath
  input  wire logic [5:0]  rx_fifo_level_i,
  input  wire logic [5:0]  tx_fifo_level_i,
  input  wire logic        rx_push_i,
  input  wire logic [3:0]  rx_err_i,
  input  wire logic        baud16_tick_i,
  // Modem inputs, active low
  input  wire logic        clear_to_send_n_i,
  input  wire logic        carrier_detect_n_i,
  input  wire logic        data_set_ready_n_i,
  input  wire logic        ring_indicator_n_i,
  // DMA handshake
  input  wire logic        tx_request_clear_i,
  input  wire logic        rx_request_clear_i,
  output logic             rx_single_request_o,
  output logic             rx_burst_request_o,
  output logic             tx_single_request_o,
  output logic             tx_burst_request_o,
  // Interrupt
  output logic             combined_irq_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Watermark in filled locations, shared by both directions
  function automatic uidr_pkg::uidr_level_t wm_fill(input logic [2:0] sel);
    case (uidr_pkg::uidr_wm_t'(sel))
      uidr_pkg::WM_1_8: wm_fill = 6'd4;
      uidr_pkg::WM_1_4: wm_fill = 6'd8;
      uidr_pkg::WM_1_2: wm_fill = 6'd16;
      uidr_pkg::WM_3_4: wm_fill = 6'd24;
      uidr_pkg::WM_7_8: wm_fill = 6'd28;
      default:          wm_fill = 6'd16;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m     = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (dat & m);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]                lcr_reg;
  logic [15:0]               cr_reg;
  logic [5:0]                ifls_reg;
  uidr_pkg::uidr_irq_vec_t   imsc_reg;
  uidr_pkg::uidr_irq_vec_t   ris_reg;
  uidr_pkg::uidr_irq_vec_t   ris_next;
  logic [2:0]                dmacr_reg;
  logic                      ack_reg;
  logic [31:0]               rdata_reg;
  logic [3:0]                modem_prev_reg;
  logic                      rx_cond_prev_reg;
  logic                      tx_cond_prev_reg;
  logic                      rxs_reg;
  logic                      rxb_reg;
  logic                      txs_reg;
  logic                      txb_reg;
  logic                      rt_pulse;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire        req_w   = wb_cyc_i && wb_stb_i;
  wire        wr_w    = req_w && wb_we_i && ack_reg;
  wire [11:0] ofs_w   = {wb_adr_i[11:2], 2'b00};
  wire        wr_lcr  = wr_w && ofs_w == `UIDR_OFS_LCR;
  wire        wr_cr   = wr_w && ofs_w == `UIDR_OFS_CR;
  wire        wr_ifls = wr_w && ofs_w == `UIDR_OFS_IFLS;
  wire        wr_imsc = wr_w && ofs_w == `UIDR_OFS_IMSC;
  wire        wr_icr  = wr_w && ofs_w == `UIDR_OFS_ICR;
  wire        wr_dma  = wr_w && ofs_w == `UIDR_OFS_DMACR;
  wire [31:0] wmask_w = merge(32'h0000_0000, 32'hffff_ffff, wb_sel_i);
  wire uidr_pkg::uidr_irq_vec_t icr_clr = wr_icr ? (wb_dat_i[10:0] & wmask_w[10:0]) : 11'h000;
  wire uidr_pkg::uidr_irq_vec_t mis_w   = ris_reg & imsc_reg;

  wire [31:0] merge_lcr  = merge({24'h0, lcr_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] merge_cr   = merge({16'h0, cr_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] merge_ifls = merge({26'h0, ifls_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] merge_imsc = merge({21'h0, imsc_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] merge_dma  = merge({29'h0, dmacr_reg}, wb_dat_i, wb_sel_i);

  logic [31:0] rd_mux;
  always_comb begin
    case (ofs_w)
      `UIDR_OFS_LCR:   rd_mux = {24'h0, lcr_reg};
      `UIDR_OFS_CR:    rd_mux = {16'h0, cr_reg};
      `UIDR_OFS_IFLS:  rd_mux = {26'h0, ifls_reg};
      `UIDR_OFS_IMSC:  rd_mux = {21'h0, imsc_reg};
      `UIDR_OFS_RIS:   rd_mux = {21'h0, ris_reg};
      `UIDR_OFS_MIS:   rd_mux = {21'h0, mis_w};
      `UIDR_OFS_DMACR: rd_mux = {29'h0, dmacr_reg};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode and level decode
  // ----------------------------------------------------------------
  wire port_en_w  = cr_reg[`UIDR_CR_PORT_EN];
  wire fifo_en_w  = lcr_reg[`UIDR_LCR_FIFO_EN];
  wire rx_dmae_w  = dmacr_reg[`UIDR_DMA_RX_EN];
  wire tx_dmae_w  = dmacr_reg[`UIDR_DMA_TX_EN];
  wire dma_block_on_error_w = dmacr_reg[`UIDR_DMA_ON_ERR];
  wire uidr_pkg::uidr_level_t rx_wm_w = wm_fill(ifls_reg[`UIDR_IFLS_RX_LSB +: 3]);
  wire uidr_pkg::uidr_level_t tx_wm_w = wm_fill(ifls_reg[`UIDR_IFLS_TX_LSB +: 3]);
  wire uidr_pkg::uidr_level_t tx_free_w = `UIDR_FIFO_DEPTH - tx_fifo_level_i;

  wire rx_nonempty_w = rx_fifo_level_i != 6'd0;
  wire tx_has_room_w = fifo_en_w ? (tx_free_w != 6'd0) : (tx_fifo_level_i == 6'd0);
  wire error_irq_w   = |ris_reg[`UIDR_IRQ_OE:`UIDR_IRQ_FE];

  // Receive burst: fill reaches watermark; transmit burst: free space reaches complement
  wire rxb_cond_w = fifo_en_w && rx_fifo_level_i >= rx_wm_w;
  wire txb_cond_w = fifo_en_w && tx_free_w >= (`UIDR_FIFO_DEPTH - tx_wm_w);

  // Per-direction gating; receive side also blocked while an error is pending
  wire rx_gate_w = port_en_w && rx_dmae_w && !(dma_block_on_error_w && error_irq_w);
  wire tx_gate_w = port_en_w && tx_dmae_w;

  // ----------------------------------------------------------------
  // DMA requests
  // ----------------------------------------------------------------
  // Sticky until clear or until the direction gate drops (bursts also when FIFOs are disabled), so a falling condition alone never withdraws a request
  wire rxs_next = (rxs_reg || rx_nonempty_w) && !rx_request_clear_i && rx_gate_w;
  wire rxb_next = (rxb_reg || rxb_cond_w) && !rx_request_clear_i && rx_gate_w && fifo_en_w;
  wire txs_next = (txs_reg || tx_has_room_w) && !tx_request_clear_i && tx_gate_w;
  wire txb_next = (txb_reg || txb_cond_w) && !tx_request_clear_i && tx_gate_w && fifo_en_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxs_reg <= 1'b0;
      rxb_reg <= 1'b0;
      txs_reg <= 1'b0;
      txb_reg <= 1'b0;
    end else begin
      rxs_reg <= rxs_next;
      rxb_reg <= rxb_next;
      txs_reg <= txs_next;
      txb_reg <= txb_next;
    end
  end

  assign rx_single_request_o = rxs_reg;
  assign rx_burst_request_o  = rxb_reg;
  assign tx_single_request_o = txs_reg;
  assign tx_burst_request_o  = txb_reg;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  wire [3:0] modem_now_w = {data_set_ready_n_i, carrier_detect_n_i, clear_to_send_n_i, ring_indicator_n_i};
  wire [3:0] modem_chg_w = modem_now_w ^ modem_prev_reg;

  wire rx_cond_w = fifo_en_w ? (rx_fifo_level_i >= rx_wm_w) : rx_nonempty_w;
  wire tx_cond_w = fifo_en_w ? (tx_fifo_level_i <= tx_wm_w) : (tx_fifo_level_i == 6'd0);
  wire rx_set_w  = rx_cond_w && !rx_cond_prev_reg;
  // Edge only: enabling with an empty FIFO must not raise it
  wire tx_set_w  = tx_cond_w && !tx_cond_prev_reg;
  wire [3:0] err_set_w = rx_push_i ? rx_err_i : 4'h0;

  uidr_rx_timeout u_rx_timeout (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (baud16_tick_i),
    .restart_i  (rx_push_i),
    .nonempty_i (rx_nonempty_w),
    .timeout_o  (rt_pulse)
  );

  // Set beats a same-cycle clear for every source
  always_comb begin
    ris_next = ris_reg & ~icr_clr;
    ris_next[`UIDR_IRQ_DSR:`UIDR_IRQ_RING] = ris_next[`UIDR_IRQ_DSR:`UIDR_IRQ_RING] | modem_chg_w;
    ris_next[`UIDR_IRQ_RX] = (ris_next[`UIDR_IRQ_RX] && rx_cond_w) || rx_set_w;
    ris_next[`UIDR_IRQ_TX] = (ris_next[`UIDR_IRQ_TX] && tx_cond_w) || tx_set_w;
    ris_next[`UIDR_IRQ_RT] = (ris_next[`UIDR_IRQ_RT] && rx_nonempty_w) || rt_pulse;
    ris_next[`UIDR_IRQ_OE:`UIDR_IRQ_FE] = ris_next[`UIDR_IRQ_OE:`UIDR_IRQ_FE] | err_set_w;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ris_reg          <= 11'h000;
      modem_prev_reg   <= 4'hf;
      rx_cond_prev_reg <= 1'b0;
      tx_cond_prev_reg <= 1'b1;
    end else begin
      ris_reg          <= ris_next;
      modem_prev_reg   <= modem_now_w;
      rx_cond_prev_reg <= rx_cond_w;
      tx_cond_prev_reg <= tx_cond_w;
    end
  end

  // Only the combined line leaves the block
  assign combined_irq_o = |mis_w;

  // ----------------------------------------------------------------
  // Register writes and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcr_reg   <= `UIDR_RST_LCR;
      cr_reg    <= `UIDR_RST_CR;
      ifls_reg  <= `UIDR_RST_IFLS;
      imsc_reg  <= `UIDR_RST_IMSC;
      dmacr_reg <= `UIDR_RST_DMACR;
    end else begin
      if (wr_lcr) lcr_reg <= merge_lcr[7:0];
      if (wr_cr) cr_reg <= merge_cr[15:0];
      if (wr_ifls) ifls_reg <= merge_ifls[5:0];
      if (wr_imsc) imsc_reg <= merge_imsc[10:0];
      if (wr_dma) dmacr_reg <= merge_dma[2:0];
    end
  end

  // Single wait state: ack one cycle after the strobe, then drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= req_w && !ack_reg;
      rdata_reg <= (req_w && !ack_reg && !wb_we_i) ? rd_mux : rdata_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rx_clear_done;
    rx_request_clear_i ##1 !rx_request_clear_i;
  endsequence

  a_req_holds: assert property ((txs_reg && !tx_request_clear_i && tx_gate_w) |=> txs_reg)
    else $error("transmit single request dropped without clear");
  a_clear_drops: assert property (rx_request_clear_i |=> !rxs_reg && !rxb_reg)
    else $error("receive requests survived clear");
  a_req_returns: assert property ((s_rx_clear_done ##0 (rx_nonempty_w && rx_gate_w)) |=> rxs_reg)
    else $error("receive single request did not reassert");
  a_burst_with_single: assert property (rxb_reg |-> rxs_reg)
    else $error("receive burst without single request");
  a_char_no_burst: assert property (!fifo_en_w |=> !rxb_reg && !txb_reg)
    else $error("burst request in character mode");
  a_disable_drops: assert property (!port_en_w |=> !rxs_reg && !rxb_reg && !txs_reg && !txb_reg)
    else $error("request active while port disabled");
  a_err_blocks_rx: assert property ((dma_block_on_error_w && error_irq_w) |=> !rxs_reg && !rxb_reg)
    else $error("receive request active during error block");
  a_tx_edge_only: assert property ($rose(ris_reg[`UIDR_IRQ_TX]) |-> !$past(tx_cond_prev_reg, 1))
    else $error("transmit interrupt set by level");
  a_modem_change: assert property ((modem_now_w != modem_prev_reg) |=> |ris_reg[`UIDR_IRQ_DSR:`UIDR_IRQ_RING])
    else $error("modem change not flagged");
  a_mask_gate: assert property ((ris_reg[`UIDR_IRQ_TX] && imsc_reg[`UIDR_IRQ_TX]) |-> combined_irq_o)
    else $error("enabled source missing from combined interrupt");
  a_all_masked: assert property ((imsc_reg == 11'h000) |-> !combined_irq_o)
    else $error("combined interrupt with all sources masked");

endmodule // uidr_core

/* File: test/uidr_dma_model.sv */
`timescale 1ns/10ps
module uidr_dma_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       go_i,
  input  wire logic [3:0] delay_i,
  // Request handshake
  input  wire logic       single_i,
  input  wire logic       burst_i,
  output logic            clear_o
);
  logic [3:0] cnt_reg;

  // Clear lasts one cycle, as on the final item of a burst
  always_ff @(posedge clk_i) begin
    if (rst_i || !go_i) begin
      cnt_reg <= 4'h0;
      clear_o <= 1'b0;
    end else if (clear_o) begin
      cnt_reg <= 4'h0;
      clear_o <= 1'b0;
    end else if (single_i || burst_i) begin
      cnt_reg <= cnt_reg + 4'h1;
      clear_o <= (cnt_reg == delay_i);
    end
  end
endmodule // uidr_dma_model

/* File: test/tb_uidr_core.sv */
`timescale 1ns/10ps
`include "uidr_defines.svh"
module tb_uidr_core;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  rxl   = 6'h00;
  logic [5:0]  txl   = 6'h00;
  logic        push  = 1'b0;
  logic        tick  = 1'b0;
  logic        rgo   = 1'b0;
  logic        tgo   = 1'b0;
  logic [3:0]  err   = 4'h0;
  logic [3:0]  mdm   = 4'hf;
  logic [3:0]  dly   = 4'h2;
  logic        rclr, tclr, rs, rb, ts, tb, irq;
  int          n_errors = 0;
  int          checks = 0;

  always #25 clk_i = ~clk_i;

  uidr_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_fifo_level_i(rxl),
    .tx_fifo_level_i(txl), .rx_push_i(push), .rx_err_i(err), .baud16_tick_i(tick),
    .clear_to_send_n_i(mdm[1]), .carrier_detect_n_i(mdm[2]), .data_set_ready_n_i(mdm[3]),
    .ring_indicator_n_i(mdm[0]), .tx_request_clear_i(tclr), .rx_request_clear_i(rclr),
    .rx_single_request_o(rs), .rx_burst_request_o(rb), .tx_single_request_o(ts),
    .tx_burst_request_o(tb), .combined_irq_o(irq));
  uidr_dma_model rdma (.clk_i(clk_i), .rst_i(rst_i), .go_i(rgo), .delay_i(dly), .single_i(rs),
    .burst_i(rb), .clear_o(rclr));
  uidr_dma_model tdma (.clk_i(clk_i), .rst_i(rst_i), .go_i(tgo), .delay_i(dly), .single_i(ts),
    .burst_i(tb), .clear_o(tclr));

  // ----
  // Tasks
  // ----
  // Called on a rising edge; inputs change there by non-blocking assignment
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Held until the edge that sees ack, then one idle cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic ris(input logic [31:0] m, input logic [31:0] e, input string nm);
    wb(1'b0, `UIDR_OFS_RIS, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic req(input logic [3:0] e, input string nm);
    chk(nm, {28'h0, e}, {28'h0, rs, rb, ts, tb});
  endtask
  // Levels must leave no condition true, or the model keeps clearing
  task automatic clr();
    rgo <= 1'b1; tgo <= 1'b1;
    step(8);
    rgo <= 1'b0; tgo <= 1'b0;
    step(2);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1; step(1); tick <= 1'b0; step(1);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rdc(`UIDR_OFS_IFLS, 32'h12, "level select");
    rdc(`UIDR_OFS_CR, 32'h300, "control");
    rdc(`UIDR_OFS_DMACR, 32'h0, "dma control");
    rdc(`UIDR_OFS_IMSC, 32'h0, "mask");
    rdc(12'h100, 32'h0, "unmapped");
    wb(1'b1, `UIDR_OFS_LCR, 32'h10);
    wb(1'b1, `UIDR_OFS_CR, 32'h1);
    wb(1'b1, `UIDR_OFS_DMACR, 32'h3);
    step(2);
    req(4'b0011, "tx empty");
    ris(32'h7ff, 32'h0, "no tx irq before data");
    txl <= 6'd32; step(2); clr();
    $display("test reset done");
  endtask
  task automatic t_bursts();
    int rt;
    for (int i = 0; i < 5; i++) begin
      rt = (i == 0) ? 4 : (i == 4) ? 28 : 8 * i;
      dly <= 4'(i);
      wb(1'b1, `UIDR_OFS_IFLS, 32'((i << 3) | (4 - i)));
      rxl <= 6'(rt - 1); txl <= 6'(33 - rt); step(3);
      req(4'b1010, "below watermark");
      rxl <= 6'(rt); txl <= 6'(32 - rt); step(3);
      req(4'b1111, "at watermark");
      rxl <= 6'd0; txl <= 6'd32; step(3);
      req(4'b1111, "held");
      clr();
      req(4'b0000, "cleared");
      rxl <= 6'(rt); step(3);
      req(4'b1100, "reasserted");
      clr();
      step(2);
      req(4'b1100, "back after clear");
      rxl <= 6'd0; clr();
    end
    $display("test bursts done");
  endtask
  task automatic t_gates();
    wb(1'b1, `UIDR_OFS_IFLS, 32'h0);
    rxl <= 6'd10; txl <= 6'd0; step(3);
    req(4'b1111, "all on");
    wb(1'b1, `UIDR_OFS_DMACR, 32'h2); step(2);
    req(4'b0011, "rx dma off");
    wb(1'b1, `UIDR_OFS_CR, 32'h0); step(2);
    req(4'b0000, "port off");
    // Char mode and a full tx location first, so no sticky request is left over
    wb(1'b1, `UIDR_OFS_LCR, 32'h0);
    rxl <= 6'd0;
    txl <= 6'd1;
    wb(1'b1, `UIDR_OFS_CR, 32'h1);
    wb(1'b1, `UIDR_OFS_DMACR, 32'h3);
    wb(1'b1, `UIDR_OFS_ICR, 32'h7ff);
    rxl <= 6'd1;
    step(3);
    req(4'b1000, "char mode");
    ris(32'h10, 32'h10, "char rx irq");
    txl <= 6'd0; step(3);
    req(4'b1010, "char mode empty");
    ris(32'h20, 32'h20, "char tx irq");
    wb(1'b1, `UIDR_OFS_ICR, 32'h30);
    ris(32'h30, 32'h0, "char irq clear");
    wb(1'b1, `UIDR_OFS_LCR, 32'h10);
    rxl <= 6'd0; txl <= 6'd32; step(2); clr();
    $display("test gates done");
  endtask
  task automatic t_err();
    wb(1'b1, `UIDR_OFS_DMACR, 32'h7);
    rxl <= 6'd10; txl <= 6'd0; step(3);
    for (int k = 0; k < 4; k++) begin
      err <= 4'(1 << k); push <= 1'b1; step(1);
      err <= 4'h0; push <= 1'b0; step(2);
      req(4'b0011, "blocked on error");
      ris(32'h780, 32'(1 << (7 + k)), "error bit");
      wb(1'b1, `UIDR_OFS_ICR, 32'(1 << (7 + k))); step(2);
      req(4'b1111, "unblocked");
    end
    wb(1'b1, `UIDR_OFS_DMACR, 32'h3);
    rxl <= 6'd0; txl <= 6'd32; step(2); clr();
    $display("test errors done");
  endtask
  task automatic t_irq();
    wb(1'b1, `UIDR_OFS_ICR, 32'h7ff);
    for (int k = 0; k < 4; k++) begin
      mdm[k] <= ~mdm[k]; step(3);
      ris(32'hf, 32'(1 << k), "modem raw");
      chk("masked irq", 32'h0, {31'h0, irq});
      wb(1'b1, `UIDR_OFS_IMSC, 32'(1 << k));
      chk("combined irq", 32'h1, {31'h0, irq});
      wb(1'b1, `UIDR_OFS_ICR, 32'(1 << k));
      chk("modem cleared", 32'h0, {31'h0, irq});
      wb(1'b1, `UIDR_OFS_IMSC, 32'h0);
    end
    wb(1'b1, `UIDR_OFS_IFLS, 32'h2);
    rxl <= 6'd3; txl <= 6'd20; step(2);
    rxl <= 6'd4; txl <= 6'd16; step(3);
    ris(32'h30, 32'h30, "fifo irqs at level");
    rxl <= 6'd3; txl <= 6'd17; step(3);
    ris(32'h30, 32'h0, "fifo irqs past level");
    rxl <= 6'd4; step(3);
    wb(1'b1, `UIDR_OFS_ICR, 32'h10);
    ris(32'h10, 32'h0, "rx irq clear");
    $display("test irq done");
  endtask
  task automatic t_timeout();
    rxl <= 6'd1; push <= 1'b1; step(1);
    push <= 1'b0;
    wb(1'b1, `UIDR_OFS_ICR, 32'h7ff);
    ticks(500);
    ris(32'h40, 32'h0, "timeout early");
    ticks(20);
    ris(32'h40, 32'h40, "timeout");
    rxl <= 6'd0; step(3);
    ris(32'h40, 32'h0, "timeout emptied");
    $display("test timeout done");
  endtask

  // ----
  // Run
  // ----
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    t_reset();
    t_bursts();
    t_gates();
    t_err();
    t_irq();
    t_timeout();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
endmodule // tb_uidr_core
